/* File: ssp_pkg.sv */
package ssp_pkg;

    // ****************************************************
    // geometry
    // ****************************************************
    localparam int ADDR_W  = 17;
    localparam int LANES   = 4;
    localparam int LANE_W  = 9;
    localparam int DATA_W  = LANES * LANE_W;
    localparam int DEPTH   = 131072;

    // ****************************************************
    // values after reset
    // ****************************************************
    localparam logic [DATA_W-1:0] DATA_RST  = 36'h0_0000_0000;
    localparam logic [ADDR_W-1:0] ADDR_RST  = 17'h0_0000;
    localparam logic [LANES-1:0]  LANES_RST = 4'h0;
    localparam logic              OE_RST      = 1'h0;
    localparam logic              OE_N_RST    = 1'h1;
    localparam logic              SLEEP_RST   = 1'h1;
    localparam logic              MODE_OK_RST = 1'h0;
    localparam logic [1:0]        MODE_RST    = 2'h0;

    // ****************************************************
    // strap code {second, first} for register-to-register
    // ****************************************************
    localparam logic [1:0]        MODE_R2R    = 2'h2;

    // ****************************************************
    // captured write command, waiting for its late data
    // ****************************************************
    typedef struct packed {
        logic              valid;
        logic [ADDR_W-1:0] addr;
        logic [LANES-1:0]  lane_en;
    } ssp_wcmd_t;

    localparam ssp_wcmd_t WCMD_RST = '{valid: 1'b0, addr: ADDR_RST,
                                       lane_en: LANES_RST};

endpackage

/* File: ssp_sram_port.sv */
`timescale 1ns/1ps

// Summary of operation
// - memory holds 128k words of 36 bits, addressed by 17 bits
// - word is four 9-bit lanes, each with its own write select
// - select, write enable, lane selects and address taken on rising edge
// - in a write only lanes with low select change, others keep data
// - write data taken one cycle after its command; bus released meanwhile
// - read with output enable low drives the whole word next cycle
// - sleep high blocks all access and releases the data bus
// - works from one single-ended clock phase alone
// - only register-to-register protocol is offered
module ssp_sram_port (
    input  wire logic                         mclk_i,            // clock
    input  wire logic                         rst_n_i,           // sync reset
    input  wire logic                         select_n_i,        // chip select
    input  wire logic                         write_enable_n_i,  // write cmd
    input  wire logic [ssp_pkg::LANES-1:0]    lane_write_n_i,    // lane sel
    input  wire logic [ssp_pkg::ADDR_W-1:0]   word_addr_i,       // address
    input  wire logic                         out_enable_n_i,    // async oe
    input  wire logic                         sleep_request_i,   // async sleep
    input  wire logic                         protocol_pin_first_i,  // mode
    input  wire logic                         protocol_pin_second_i, // mode
    input  wire logic [ssp_pkg::DATA_W-1:0]   data_i,            // bus in
    output logic      [ssp_pkg::DATA_W-1:0]   data_o,            // bus out
    output logic                              data_oe_o          // bus drive
);

    // ****************************************************
    // storage
    // ****************************************************
    // one array of full words; lanes are picked apart on write and when a read bypasses a pending write
    logic [ssp_pkg::DATA_W-1:0] mem_q [ssp_pkg::DEPTH];

    // ****************************************************
    // helpers
    // ****************************************************
    // per-lane merge: enabled lanes take new data, others keep old
    function automatic logic [ssp_pkg::DATA_W-1:0] merge_lanes(
        input logic [ssp_pkg::DATA_W-1:0] old_w,
        input logic [ssp_pkg::DATA_W-1:0] new_w,
        input logic [ssp_pkg::LANES-1:0]  en
    );
        logic [ssp_pkg::DATA_W-1:0] r;
        r = old_w;
        for (int i = 0; i < ssp_pkg::LANES; i++)
        begin
            if (en[i])
            begin
                r[i*ssp_pkg::LANE_W +: ssp_pkg::LANE_W] =
                    new_w[i*ssp_pkg::LANE_W +: ssp_pkg::LANE_W];
            end
        end
        return r;
    endfunction

    // ****************************************************
    // synchronisers for the asynchronous pins
    // ****************************************************
    logic       oe_n_meta_q;
    logic       oe_n_q;
    logic       sleep_meta_q;
    logic       sleep_q;
    logic [1:0] mode_meta_q;
    logic [1:0] mode_q;
    logic       mode_ok_q;

    // reset to disabled so no read is served before the pin is seen
    always_ff @(posedge mclk_i)
    begin
        if (!rst_n_i)
        begin
            oe_n_meta_q <= ssp_pkg::OE_N_RST;
            oe_n_q      <= ssp_pkg::OE_N_RST;
        end
        else
        begin
            oe_n_meta_q <= out_enable_n_i;
            oe_n_q      <= oe_n_meta_q;
        end
    end

    // reset to asleep: access waits until the pin has been sampled twice
    always_ff @(posedge mclk_i)
    begin
        if (!rst_n_i)
        begin
            sleep_meta_q <= ssp_pkg::SLEEP_RST;
            sleep_q      <= ssp_pkg::SLEEP_RST;
        end
        else
        begin
            sleep_meta_q <= sleep_request_i;
            sleep_q      <= sleep_meta_q;
        end
    end

    // ****************************************************
    // protocol straps
    // ****************************************************
    // mode straps are static; a wrong strap simply disables the port
    always_ff @(posedge mclk_i)
    begin
        if (!rst_n_i)
        begin
            mode_meta_q <= ssp_pkg::MODE_RST;
            mode_q      <= ssp_pkg::MODE_RST;
            mode_ok_q   <= ssp_pkg::MODE_OK_RST;
        end
        else
        begin
            mode_meta_q <= {protocol_pin_second_i, protocol_pin_first_i};
            mode_q      <= mode_meta_q;
            mode_ok_q   <= (mode_q == ssp_pkg::MODE_R2R);
        end
    end

    // ****************************************************
    // command decode on the rising edge
    // ****************************************************
    // command pins share the timing of mclk_i, so they are used unsynchronised
    // single clock input: a single-ended clock phase is all that is needed
    logic                        active;
    logic                        do_write;
    logic                        do_read;
    logic [ssp_pkg::LANES-1:0]   lane_en;

    always_comb
    begin
        active   = mode_ok_q && !sleep_q && !select_n_i;
        do_write = active && !write_enable_n_i;
        do_read  = active && write_enable_n_i && !oe_n_q;
        lane_en  = ~lane_write_n_i;
    end

    // ****************************************************
    // late write: command now, data at the next edge
    // ****************************************************
    // address and lanes are taken every edge; valid alone marks a write
    ssp_pkg::ssp_wcmd_t wcmd_q;
    logic               wr_now;

    always_comb
    begin
        // sleep arriving between command and data cancels the write
        wr_now = wcmd_q.valid && !sleep_q;
    end

    always_ff @(posedge mclk_i)
    begin
        if (!rst_n_i)
        begin
            wcmd_q <= ssp_pkg::WCMD_RST;
        end
        else
        begin
            wcmd_q.valid   <= do_write;
            wcmd_q.addr    <= word_addr_i;
            wcmd_q.lane_en <= lane_en;
        end
    end

    // ****************************************************
    // memory write
    // ****************************************************
    // memory has no reset; contents are undefined after power-up
    always_ff @(posedge mclk_i)
    begin
        if (wr_now)
        begin
            mem_q[wcmd_q.addr] <= merge_lanes(mem_q[wcmd_q.addr], data_i,
                                              wcmd_q.lane_en);
        end
    end

    // ****************************************************
    // read path, registered output
    // ****************************************************
    logic [ssp_pkg::DATA_W-1:0] rd_word;

    always_comb
    begin
        // a read right behind a write to the same word sees the new data
        rd_word = mem_q[word_addr_i];
        if (wr_now && wcmd_q.addr == word_addr_i)
        begin
            rd_word = merge_lanes(rd_word, data_i, wcmd_q.lane_en);
        end
    end

    // ****************************************************
    // output drive
    // ****************************************************
    // writes, deselects, sleep and dummy reads all release the bus
    always_ff @(posedge mclk_i)
    begin
        if (!rst_n_i)
        begin
            data_oe_o <= ssp_pkg::OE_RST;
        end
        else
        begin
            data_oe_o <= do_read;
        end
    end

    // last read word stays put; only data_oe_o says whether it is valid
    always_ff @(posedge mclk_i)
    begin
        if (!rst_n_i)
        begin
            data_o <= ssp_pkg::DATA_RST;
        end
        else if (do_read)
        begin
            data_o <= rd_word;
        end
    end

endmodule // ssp_sram_port

/* File: ssp_sram_port_sva.sv */
`timescale 1ns/1ps
// ****
// port checker
// ****
module ssp_sram_port_sva (
    input  wire logic                       mclk_i,           // clock
    input  wire logic                       rst_n_i,          // sync reset
    input  wire logic                       select_n_i,       // select
    input  wire logic                       write_enable_n_i, // write cmd
    input  wire logic                       out_enable_n_i,   // oe
    input  wire logic                       sleep_request_i,  // sleep
    input  wire logic [ssp_pkg::DATA_W-1:0] data_o,           // read data
    input  wire logic                       data_oe_o         // bus drive
);
    logic [2:0] up_q;
    logic       rd;
    logic       quiet;
    assign rd = !select_n_i && write_enable_n_i;
    assign quiet = !out_enable_n_i && !sleep_request_i;
    // synchronisers need a few edges after reset before reads are served
    always_ff @(posedge mclk_i)
        if (!rst_n_i) up_q <= 3'h0;
        else if (up_q != 3'h7) up_q <= up_q + 3'h1;
    default clocking @(posedge mclk_i); endclocking
    default disable iff (!rst_n_i);
    a_idle_no_drive: assert property (select_n_i |=> !data_oe_o)
        else $error("bus driven after idle edge");
    a_write_no_drive: assert property (
        !select_n_i && !write_enable_n_i |=> !data_oe_o)
        else $error("bus driven after write command");
    a_sleep_no_drive: assert property (
        sleep_request_i [*3] |=> !data_oe_o)
        else $error("bus driven while asleep");
    a_oe_gate_off: assert property (
        out_enable_n_i [*3] |=> !data_oe_o)
        else $error("bus driven with output enable high");
    a_read_drives: assert property (
        quiet [*3] ##0 (rd && up_q == 3'h7) |=> data_oe_o)
        else $error("read not driven next cycle");
    a_drive_has_read: assert property (data_oe_o |-> $past(rd))
        else $error("bus driven without read");
    a_drive_when_quiet: assert property (
        data_oe_o |-> $past(quiet, 3))
        else $error("bus driven despite oe or sleep");
    a_data_holds: assert property (!$past(rd) |-> $stable(data_o))
        else $error("read data changed without read");
    c_read: cover property (rd ##1 data_oe_o);
    c_write: cover property (!select_n_i && !write_enable_n_i);
    c_sleep: cover property (sleep_request_i [*3]);
endmodule // ssp_sram_port_sva

bind ssp_sram_port ssp_sram_port_sva u_ssp_sram_port_sva (.*);

/* File: ssp_host_bfm.sv */
`timescale 1ns/1ps
// ****
// late-write controller with reference memory
// ****
module ssp_host_bfm (
    input  wire logic        mclk_i,   // clock
    output logic             sel_n_o,  // select
    output logic             we_n_o,   // write cmd
    output logic [3:0]       lane_n_o, // lane selects
    output logic [16:0]      addr_o,   // address
    output logic             oe_n_o,   // output enable
    output logic             sleep_o,  // sleep
    output logic [35:0]      wdata_o   // write data
);
    logic [35:0] ref_q [int];
    logic [35:0] exp_q [$];
    logic        pend = 1'b0;
    logic [35:0] pend_d;
    initial {sel_n_o, we_n_o, lane_n_o, addr_o, oe_n_o, sleep_o} = 25'h1FE0000;
    initial wdata_o = 36'h0;
    task automatic op(input logic s, w, input logic [3:0] ln,
                      input logic [16:0] a, input logic [35:0] d);
        @(negedge mclk_i);
        // bus not owned by data: keep it moving so stale values never match
        wdata_o = pend ? pend_d : ~wdata_o;
        {sel_n_o, we_n_o, lane_n_o, addr_o} = {s, !w, ln, a};
        pend = !s && w;
        pend_d = d;
        if (!s && !sleep_o && !ref_q.exists(a)) ref_q[a] = 'x;
        for (int i = 0; i < 4; i++)
            if (pend && !sleep_o && !ln[i]) ref_q[a][9*i+:9] = d[9*i+:9];
        if (!s && !w && !oe_n_o && !sleep_o) exp_q.push_back(ref_q[a]);
    endtask
    task automatic nop(input int n);
        repeat (n) op(1'b1, 1'b0, 4'hF, 17'h0, 36'h0);
    endtask
    task automatic mode(input logic oe_n, sl);
        {oe_n_o, sleep_o} = {oe_n, sl};
        nop(3);
    endtask
endmodule // ssp_host_bfm

/* File: ssp_sram_port_test.sv */
`timescale 1ns/1ps
module ssp_sram_port_test;
    logic        mclk_i = 1'b0;
    logic        rst_n_i = 1'b0;
    logic        select_n_i, write_enable_n_i, out_enable_n_i;
    logic        sleep_request_i, data_oe_o;
    logic [3:0]  lane_write_n_i;
    logic [16:0] word_addr_i, a;
    logic [35:0] data_i, data_o, e, d;
    int          bad_count = 0;
    int          n_compared = 0;
    always #5 mclk_i = ~mclk_i;
    ssp_host_bfm u_ssp_host_bfm (.mclk_i(mclk_i), .sel_n_o(select_n_i),
        .we_n_o(write_enable_n_i), .lane_n_o(lane_write_n_i),
        .addr_o(word_addr_i), .oe_n_o(out_enable_n_i),
        .sleep_o(sleep_request_i), .wdata_o(data_i));
    ssp_sram_port u_ssp_sram_port (.*, .protocol_pin_first_i(1'b0),
        .protocol_pin_second_i(1'b1));
    task automatic bad(input string m);
        bad_count++;
        $display("BAD %0t %s", $time, m);
    endtask
    task automatic results;
        $display("compared %0d bad %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    always @(negedge mclk_i)
        if (data_oe_o === 1'b1)
        begin
            n_compared++;
            if (u_ssp_host_bfm.exp_q.size() == 0) bad("stray drive");
            else
            begin
                e = u_ssp_host_bfm.exp_q.pop_front();
                if (data_o !== e) bad("read data wrong");
            end
        end
        else if (data_oe_o !== 1'b0) bad("drive unknown");
    initial
    begin
        #50000;
        bad("watchdog");
        results();
    end
    initial
    begin
        void'($urandom(32'h94A7));
        repeat (8) @(negedge mclk_i);
        rst_n_i = 1'b1;
        u_ssp_host_bfm.nop(4);
        for (int m = 0; m < 16; m++)
        begin
            a = 17'($urandom);
            d = 36'({$urandom, $urandom});
            u_ssp_host_bfm.op(1'b0, 1'b1, 4'h0, a, d);
            u_ssp_host_bfm.op(1'b0, 1'b1, 4'(m), a, ~d);
            u_ssp_host_bfm.op(1'b0, 1'b0, 4'hF, a, d);
        end
        foreach (d[i]) if (i < 2)
        begin
            a = i ? 17'h1FFFF : 17'h0;
            u_ssp_host_bfm.op(1'b0, 1'b1, 4'h0, a, {4{9'(i + 3)}});
            u_ssp_host_bfm.nop(1);
            u_ssp_host_bfm.op(1'b0, 1'b0, 4'hF, a, d);
        end
        u_ssp_host_bfm.mode(1'b1, 1'b0);
        u_ssp_host_bfm.op(1'b0, 1'b0, 4'hF, a, d);
        u_ssp_host_bfm.mode(1'b0, 1'b1);
        u_ssp_host_bfm.op(1'b0, 1'b1, 4'h0, a, 36'h0);
        u_ssp_host_bfm.op(1'b0, 1'b0, 4'hF, a, d);
        u_ssp_host_bfm.mode(1'b0, 1'b0);
        u_ssp_host_bfm.op(1'b0, 1'b0, 4'hF, a, d);
        u_ssp_host_bfm.nop(4);
        n_compared++;
        if (u_ssp_host_bfm.exp_q.size() != 0) bad("read missing");
        results();
    end
endmodule // ssp_sram_port_test
